/* verilog/sees_defs.svh */
// constants of the serial eeprom slave: opcodes, status bit positions, timing
// included by bare name from the design files
`ifndef SEES_DEFS_SVH
`define SEES_DEFS_SVH

// opcode fields: upper nibble zero, bit 3 ignored, low three bits select
`define SEES_OP_HI_NIBBLE 4'h0
`define SEES_OP_SET_WL 3'h6
`define SEES_OP_CLR_WL 3'h4
`define SEES_OP_RD_STAT 3'h5
`define SEES_OP_WR_STAT 3'h1
`define SEES_OP_RD_ARRAY 3'h3
`define SEES_OP_WR_ARRAY 3'h2
// identification page access, full eight-bit codes
`define SEES_OP_ID_RD 8'h83
`define SEES_OP_ID_WR 8'h82
// address bit that selects the lock word of the identification page
`define SEES_ID_LOCK_BIT 10

// status register layout
`define SEES_ST_BUSY 0
`define SEES_ST_WEL 1
`define SEES_ST_BP_LO 2
`define SEES_ST_BP_HI 3
`define SEES_ST_ARM 7
`define SEES_ST_BUSY_VIEW 8'hFF
`define SEES_ST_GAP 3'h0

// block protect codes
`define SEES_BP_QUARTER 2'h1
`define SEES_BP_HALF 2'h2
`define SEES_BP_ALL 2'h3
`define SEES_QUARTER_TOP 2'h3

// serial framing
`define SEES_LAST_BIT 3'h7
`define SEES_FIRST_BIT 3'h0
`define SEES_BIT_STEP 3'h1

// self-timed write, longest time in ms and system clock rate in MHz
`define SEES_WRITE_TIME_MS 5
`define SEES_CLK_MHZ 125

`endif

/* verilog/sees_pkg.sv */
// types shared by the serial eeprom slave
// no dependencies
package sees_pkg;

	// decoded instruction
	typedef enum logic [3:0] {
		cmd_none,
		cmd_set_wl,
		cmd_clr_wl,
		cmd_rd_stat,
		cmd_wr_stat,
		cmd_rd_array,
		cmd_wr_array,
		cmd_id_rd,
		cmd_id_wr
	} sees_cmd_t;

	// position within a frame
	typedef enum logic [2:0] {
		ph_opcode,
		ph_addr_hi,
		ph_addr_lo,
		ph_data,
		ph_ignore
	} sees_phase_t;

	// nonvolatile job held during the write cycle
	typedef enum logic [2:0] {
		job_none,
		job_status,
		job_array,
		job_id,
		job_lock
	} sees_job_t;

endpackage : sees_pkg

/* verilog/sees_sync.sv */
// two-flop level synchroniser, any width
// assumes each bit is a level; multi-bit words must be quasi-static or coherent
`timescale 1ns/1ps
module sees_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sees_sync_t;

	sees_sync_t st;
	sees_sync_t next_st;

	// first stage feeds only the second
	always_comb
	begin
		next_st.stage1 = d_in;
		next_st.stage2 = st.stage1;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st.stage1 <= RESET_VAL;
			st.stage2 <= RESET_VAL;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign q_out = st.stage2;

endmodule : sees_sync

/* verilog/sees_write_timer.sv */
// self-timed write cycle counter on the system clock
// assumes start_in is a one-cycle pulse and CYCLES is at least one
`timescale 1ns/1ps
module sees_write_timer #(
	parameter int CYCLES = 625000
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	output logic busy_out,
	output logic done_out
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);
	localparam logic [CW-1:0] ONE = CW'(1);

	typedef struct packed {
		logic [CW-1:0] count;
		logic busy;
		logic done;
	} sees_timer_t;

	sees_timer_t st;
	sees_timer_t next_st;

	// count down; done pulses in the cycle busy falls
	always_comb
	begin
		next_st = st;
		next_st.done = 1'b0;
		if (st.busy)
		begin
			if (st.count == ONE)
			begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end
			next_st.count = st.count - ONE;
		end
		else if (start_in)
		begin
			next_st.busy = 1'b1;
			next_st.count = LOAD;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign busy_out = st.busy;
	assign done_out = st.done;

endmodule : sees_write_timer

/* verilog/sees_top.sv */
// serial eeprom slave: spi front end, status, protection, array and id page
// assumes the host keeps spi timing; sck is a second clock domain
// Operation
// - sample input on rising sck, shift read data out on falling sck.
// - work in clock modes zero and three, either idle clock level.
// - all bytes travel most significant bit first.
// - first byte after select falls is the opcode; invalid ones ignored.
// - select rising ends the frame and launches any queued write.
// - deselected and idle means standby with output released.
// - nonvolatile writes are self timed, at most five milliseconds.
// - 16384 bytes in 64-byte pages; byte, partial or full page writes.
// - hold low freezes clock, input and output; release resumes.
// - hold tied high means normal operation.
// - write-protect low with arm bit set freezes protect and arm bits.
// - block protection covers a quarter, half or all of the array.
// - extra 64-byte id page, writable, then lockable read-only.
// - reset ignores instructions, initialises and enters standby.
// - opcode set and sixteen address bits after array opcodes.
// - write latch clears at reset and after clear, status or array write.
// - during a write cycle only status read is accepted; busy shown.
// - protect code picks none, 3000h up, 2000h up, or everything.
`timescale 1ns/1ps
`include "sees_defs.svh"
module sees_top #(
	parameter int ARRAY_BYTES = 16384,
	parameter int PAGE_BYTES = 64,
	parameter int WRITE_CYCLES = `SEES_WRITE_TIME_MS * 1000 * `SEES_CLK_MHZ
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic spi_sck_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_si_in,
	input wire logic spi_hold_n_in,
	input wire logic wp_n_in,
	output logic spi_so_out,
	output logic spi_so_oe_out,
	output logic standby_out,
	output logic write_busy_out
);

	localparam int AW = $clog2(ARRAY_BYTES);
	localparam int PW = $clog2(PAGE_BYTES);

	// link state, cleared whenever select is high
	typedef struct packed {
		logic [2:0] bitcnt;
		sees_pkg::sees_phase_t phase;
		sees_pkg::sees_cmd_t cmd;
		logic [7:0] shreg;
		logic [15:0] addr;
		logic [PW-1:0] idx;
	} sees_link_t;

	// command handed to the system side; survives select rising
	typedef struct packed {
		logic stamp;
		sees_pkg::sees_cmd_t cmd;
		logic [15:0] base;
		logic [7:0] data;
		logic [PAGE_BYTES-1:0][7:0] page;
		logic [PAGE_BYTES-1:0] mask;
	} sees_pend_t;

	// system side state, array and id page included
	typedef struct packed {
		logic seen;
		logic cs_prev;
		logic wel;
		logic [1:0] bp;
		logic arm;
		logic id_lock;
		sees_pkg::sees_job_t job;
		logic [7:0] stat;
		logic standby;
		logic start;
		logic [ARRAY_BYTES-1:0][7:0] mem;
		logic [PAGE_BYTES-1:0][7:0] id_page;
	} sees_sys_t;

	sees_link_t lk;
	sees_link_t next_lk;
	sees_pend_t pd;
	sees_pend_t next_pd;
	sees_sys_t sys;
	sees_sys_t next_sys;
	logic [7:0] shout;
	logic [7:0] next_shout;
	logic so_oe;
	logic next_so_oe;

	logic link_rst;
	logic [7:0] stat_l;
	logic busy_l;
	logic cs_s;
	logic wp_s;
	logic t_busy;
	logic t_done;
	logic [7:0] sh;
	sees_pkg::sees_cmd_t dec;
	logic [7:0] rd_byte;
	logic reading;
	logic hw_prot;
	logic page_prot;

	// select high holds the link in reset, so its fall starts a frame
	assign link_rst = rst_in | spi_cs_n_in;

	// status crosses to sck; reset value reads as busy so nothing slips through
	sees_sync #(
		.WIDTH(8),
		.RESET_VAL(`SEES_ST_BUSY_VIEW)
	) u_stat_sync (
		.clk_in(spi_sck_in),
		.rst_in(rst_in),
		.d_in(sys.stat),
		.q_out(stat_l)
	);

	// select and write-protect pins into the system domain
	sees_sync #(
		.WIDTH(2),
		.RESET_VAL(2'h3)
	) u_pin_sync (
		.clk_in(clk_sys_in),
		.rst_in(rst_in),
		.d_in({spi_cs_n_in, wp_n_in}),
		.q_out({cs_s, wp_s})
	);

	// self-timed write, counted on the system clock only
	sees_write_timer #(
		.CYCLES(WRITE_CYCLES)
	) u_timer (
		.clk_in(clk_sys_in),
		.rst_in(rst_in),
		.start_in(sys.start),
		.busy_out(t_busy),
		.done_out(t_done)
	);

	assign busy_l = stat_l[`SEES_ST_BUSY];
	// msb first: each new bit enters at the bottom
	assign sh = {lk.shreg[6:0], spi_si_in};

	// opcode decode; bit 3 is ignored
	always_comb
	begin
		dec = sees_pkg::cmd_none;
		if (sh == `SEES_OP_ID_RD)
			dec = sees_pkg::cmd_id_rd;
		else if (sh == `SEES_OP_ID_WR)
			dec = sees_pkg::cmd_id_wr;
		else if (sh[7:4] == `SEES_OP_HI_NIBBLE)
		begin
			case (sh[2:0])
				`SEES_OP_SET_WL: dec = sees_pkg::cmd_set_wl;
				`SEES_OP_CLR_WL: dec = sees_pkg::cmd_clr_wl;
				`SEES_OP_RD_STAT: dec = sees_pkg::cmd_rd_stat;
				`SEES_OP_WR_STAT: dec = sees_pkg::cmd_wr_stat;
				`SEES_OP_RD_ARRAY: dec = sees_pkg::cmd_rd_array;
				`SEES_OP_WR_ARRAY: dec = sees_pkg::cmd_wr_array;
				default: dec = sees_pkg::cmd_none;
			endcase
		end
	end

	// rising-edge link sequencer
	always_comb
	begin
		next_lk = lk;
		next_pd = pd;
		// hold low: the edge is ignored and all state kept
		// hold is stable at every sck edge, so it is read directly
		// hold tied high simply never freezes
		if (spi_hold_n_in)
		begin
			next_lk.shreg = sh;
			next_lk.bitcnt = lk.bitcnt + `SEES_BIT_STEP;
			if (lk.bitcnt == `SEES_LAST_BIT)
			begin
				case (lk.phase)
					sees_pkg::ph_opcode:
					begin
						next_lk.cmd = dec;
						// unknown opcode: rest of frame ignored
						// while busy only status read passes
						if (dec == sees_pkg::cmd_none || (busy_l && dec != sees_pkg::cmd_rd_stat))
							next_lk.phase = sees_pkg::ph_ignore;
						else if (dec == sees_pkg::cmd_set_wl || dec == sees_pkg::cmd_clr_wl)
						begin
							next_pd.cmd = dec;
							next_pd.stamp = ~pd.stamp;
							next_lk.phase = sees_pkg::ph_ignore;
						end
						else if (dec == sees_pkg::cmd_rd_stat || dec == sees_pkg::cmd_wr_stat)
							next_lk.phase = sees_pkg::ph_data;
						else
							next_lk.phase = sees_pkg::ph_addr_hi;
					end
					sees_pkg::ph_addr_hi:
					begin
						next_lk.addr[15:8] = sh;
						next_lk.phase = sees_pkg::ph_addr_lo;
					end
					sees_pkg::ph_addr_lo:
					begin
						next_lk.addr[7:0] = sh;
						next_lk.idx = sh[PW-1:0];
						next_lk.phase = sees_pkg::ph_data;
						if (lk.cmd == sees_pkg::cmd_wr_array || lk.cmd == sees_pkg::cmd_id_wr)
						begin
							next_pd.cmd = lk.cmd;
							next_pd.base = {lk.addr[15:8], sh};
							next_pd.mask = '0;
						end
					end
					sees_pkg::ph_data:
					begin
						if (lk.cmd == sees_pkg::cmd_wr_stat)
						begin
							next_pd.cmd = lk.cmd;
							next_pd.data = sh;
							next_pd.stamp = ~pd.stamp;
							next_lk.phase = sees_pkg::ph_ignore;
						end
						else if (lk.cmd == sees_pkg::cmd_wr_array || lk.cmd == sees_pkg::cmd_id_wr)
						begin
							// bytes gather in a page buffer, wrapping in the page
							next_pd.page[lk.idx] = sh;
							next_pd.mask[lk.idx] = 1'b1;
							next_lk.idx = lk.idx + PW'(1);
							// armed once, on the first whole data byte
							if (pd.mask == '0)
								next_pd.stamp = ~pd.stamp;
						end
						else
						begin
							next_lk.addr = lk.addr + 16'h0001; // sequential read
						end
					end
					default:
						next_lk.phase = lk.phase;
				endcase
			end
		end
	end

	always_ff @(posedge spi_sck_in or posedge link_rst)
	begin
		if (link_rst)
		begin
			lk <= '0;
		end
		else
		begin
			lk <= next_lk;
		end
	end

	// pending command must outlive select, so only power-on reset clears it
	always_ff @(posedge spi_sck_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pd <= '0;
		end
		else
		begin
			pd <= next_pd;
		end
	end

	// read data source; array is only written while reads are refused
	always_comb
	begin
		reading = (lk.phase == sees_pkg::ph_data) && (lk.cmd == sees_pkg::cmd_rd_stat ||
			lk.cmd == sees_pkg::cmd_rd_array || lk.cmd == sees_pkg::cmd_id_rd);
		case (lk.cmd)
			sees_pkg::cmd_rd_stat: rd_byte = stat_l;
			sees_pkg::cmd_rd_array: rd_byte = sys.mem[lk.addr[AW-1:0]];
			sees_pkg::cmd_id_rd:
			begin
				if (lk.addr[`SEES_ID_LOCK_BIT])
					rd_byte = {7'h00, sys.id_lock};
				else
					rd_byte = sys.id_page[lk.addr[PW-1:0]];
			end
			default: rd_byte = 8'h00;
		endcase
	end

	// falling-edge output shifter
	always_comb
	begin
		next_shout = shout;
		// drive only in the data-return phase of reads
		next_so_oe = reading;
		if (spi_hold_n_in && reading)
		begin
			// in mode 3 the leading fall sees no read phase, so both modes align
			// byte loads whole, bit 7 leaves first
			if (lk.bitcnt == `SEES_FIRST_BIT)
				next_shout = rd_byte;
			else
				next_shout = {shout[6:0], 1'b0};
		end
	end

	always_ff @(negedge spi_sck_in or posedge link_rst)
	begin
		if (link_rst)
		begin
			shout <= 8'h00;
		end
		else
		begin
			shout <= next_shout;
		end
	end

	// select high releases the output immediately
	always_ff @(negedge spi_sck_in or posedge link_rst)
	begin
		if (link_rst)
		begin
			so_oe <= 1'b0;
		end
		else
		begin
			so_oe <= next_so_oe;
		end
	end

	// hardware protection: pin low and arm bit set
	assign hw_prot = sys.arm & ~wp_s;

	// protected range chosen by the two protect bits
	// quarter is the top 4K, half the top 8K, or all
	always_comb
	begin
		page_prot = 1'b0;
		if (sys.bp == `SEES_BP_ALL)
			page_prot = 1'b1;
		else if (sys.bp == `SEES_BP_HALF)
			page_prot = pd.base[AW-1];
		else if (sys.bp == `SEES_BP_QUARTER)
			page_prot = (pd.base[AW-1:AW-2] == `SEES_QUARTER_TOP);
	end

	// system side: execute at frame end, commit at end of write cycle
	always_comb
	begin
		next_sys = sys;
		next_sys.start = 1'b0;
		next_sys.cs_prev = cs_s;
		// select rising ends the frame and launches the queued job
		if (cs_s && !sys.cs_prev && pd.stamp != sys.seen && !t_busy && sys.job == sees_pkg::job_none)
		begin
			next_sys.seen = pd.stamp;
			case (pd.cmd)
				sees_pkg::cmd_set_wl:
					next_sys.wel = 1'b1;
				sees_pkg::cmd_clr_wl:
					next_sys.wel = 1'b0;
				sees_pkg::cmd_wr_stat:
				begin
					if (sys.wel && !hw_prot)
					begin
						next_sys.job = sees_pkg::job_status;
						next_sys.start = 1'b1;
					end
				end
				sees_pkg::cmd_wr_array:
				begin
					if (sys.wel)
					begin
						next_sys.job = sees_pkg::job_array;
						next_sys.start = 1'b1;
					end
				end
				sees_pkg::cmd_id_wr:
				begin
					// a locked id page refuses every write
					if (sys.wel && !sys.id_lock)
					begin
						next_sys.job = pd.base[`SEES_ID_LOCK_BIT] ? sees_pkg::job_lock : sees_pkg::job_id;
						next_sys.start = 1'b1;
					end
				end
				default:
					next_sys.seen = pd.stamp;
			endcase
		end
		if (t_done)
		begin
			case (sys.job)
				sees_pkg::job_status:
				begin
					next_sys.bp = {pd.data[`SEES_ST_BP_HI], pd.data[`SEES_ST_BP_LO]};
					next_sys.arm = pd.data[`SEES_ST_ARM];
				end
				sees_pkg::job_array:
				begin
					for (int i = 0; i < PAGE_BYTES; i++)
					begin
						if (pd.mask[i] && !page_prot)
							next_sys.mem[{pd.base[AW-1:PW], PW'(i)}] = pd.page[i];
					end
				end
				sees_pkg::job_id:
				begin
					for (int i = 0; i < PAGE_BYTES; i++)
					begin
						if (pd.mask[i])
							next_sys.id_page[i] = pd.page[i];
					end
				end
				sees_pkg::job_lock:
					next_sys.id_lock = 1'b1;
				default:
					next_sys.id_lock = sys.id_lock;
			endcase
			// latch clears on completion of any write
			next_sys.wel = 1'b0;
			next_sys.job = sees_pkg::job_none;
		end
		// all ones while a write runs, ready bit included
		if (t_busy || sys.job != sees_pkg::job_none || next_sys.start)
			next_sys.stat = `SEES_ST_BUSY_VIEW;
		else
			next_sys.stat = {sys.arm, `SEES_ST_GAP, sys.bp, sys.wel, 1'b0};
		// standby once deselected and no write remains
		next_sys.standby = cs_s && !t_busy && sys.job == sees_pkg::job_none && !next_sys.start;
	end

	// reset: latch and state cleared, standby entered
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sys <= '0;
			sys.cs_prev <= 1'b1;
			sys.standby <= 1'b1;
		end
		else
		begin
			sys <= next_sys;
		end
	end

	assign spi_so_out = shout[7];
	// hold low releases the pin at once; the enable flop keeps its state
	// so the pending bit is driven again before the first rise after release
	assign spi_so_oe_out = so_oe & spi_hold_n_in;
	assign standby_out = sys.standby;
	assign write_busy_out = t_busy;

endmodule : sees_top

/* testbench/sees_assertions.sv */
// port-level checks on the serial eeprom slave
// assumes it is bound to sees_top; samples on the system clock
`timescale 1ns/1ps
module sees_assertions #(
	parameter int ARRAY_BYTES = 16384,
	parameter int PAGE_BYTES = 64,
	parameter int WRITE_CYCLES = 625000
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_hold_n_in,
	input wire logic spi_so_oe_out,
	input wire logic standby_out,
	input wire logic write_busy_out
);
	int busy_len;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// length of the running write cycle, cleared when idle
	always_ff @(posedge clk_sys_in or posedge rst_in)
		if (rst_in)
			busy_len <= 0;
		else
			busy_len <= write_busy_out ? busy_len + 1 : 0;
	a_deselect_quiet: assert property (spi_cs_n_in |-> !spi_so_oe_out)
		else $error("output enabled while deselected");
	a_hold_quiet: assert property (!spi_hold_n_in |-> !spi_so_oe_out)
		else $error("output enabled during hold");
	a_busy_no_standby: assert property (write_busy_out |-> !standby_out)
		else $error("standby during write cycle");
	a_select_wakes: assert property (!spi_cs_n_in [*5] |-> !standby_out)
		else $error("standby while selected");
	a_write_bounded: assert property (write_busy_out |-> busy_len < WRITE_CYCLES + 2)
		else $error("write cycle too long");
	a_write_full: assert property ($fell(write_busy_out) |-> busy_len >= WRITE_CYCLES - 1)
		else $error("write cycle too short");
	a_launch_deselect: assert property ($rose(write_busy_out) |-> $past(spi_cs_n_in, 2))
		else $error("write launched while selected");
	a_reset_standby: assert property ($fell(rst_in) |-> standby_out && !write_busy_out)
		else $error("not in standby after reset");
	c_write: cover property ($rose(write_busy_out));
	c_read: cover property ($rose(spi_so_oe_out));
	c_hold: cover property (!spi_cs_n_in && !spi_hold_n_in);
endmodule : sees_assertions
bind sees_top sees_assertions #(
	.ARRAY_BYTES(ARRAY_BYTES),
	.PAGE_BYTES(PAGE_BYTES),
	.WRITE_CYCLES(WRITE_CYCLES)
) sees_assertions_i (
	.clk_sys_in(clk_sys_in),
	.rst_in(rst_in),
	.spi_cs_n_in(spi_cs_n_in),
	.spi_hold_n_in(spi_hold_n_in),
	.spi_so_oe_out(spi_so_oe_out),
	.standby_out(standby_out),
	.write_busy_out(write_busy_out)
);

/* testbench/sees_host_model.sv */
// host spi master model: 12 ns sck only inside frames
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
module sees_host_model (
	input wire logic so_in,
	input wire logic so_oe_in,
	output logic sck_out,
	output logic cs_n_out,
	output logic si_out,
	output logic hold_n_out
);
	logic cpol = 1'b0;
	int hold_bit = -1;
	// idle pins
	initial
	begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		si_out = 1'b0;
		hold_n_out = 1'b1;
	end
	// frame opens with select falling, clock idle
	task start;
		sck_out = cpol;
		#6 cs_n_out = 1'b0;
		#6;
	endtask : start
	// msb first; hold moves only with sck low
	task xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			sck_out = 1'b0;
			si_out = tx[i];
			if (i == hold_bit)
			begin
				#3 hold_n_out = 1'b0;
				si_out = ~tx[i]; // noise the device must ignore
				repeat (4) #6 sck_out = ~sck_out;
				si_out = tx[i];
				#3 hold_n_out = 1'b1;
			end
			#6 sck_out = 1'b1;
			rx[i] = so_oe_in ? so_in : 1'bx; // released line reads unknown
			#6;
		end
	endtask : xfer
	// select rises after last bit, stays high 40 ns
	task stop;
		sck_out = cpol;
		#6 cs_n_out = 1'b1;
		si_out = ~si_out;
		#40;
	endtask : stop
endmodule : sees_host_model

/* testbench/sees_top_bench.sv */
// self-checking bench for the serial eeprom slave
// assumes sees_host_model as the spi master; short write cycle
`timescale 1ns/1ps
module sees_top_bench;
	localparam int WC = 200;
	logic clk_sys_in, rst_in, wp_n_in, sck, cs_n, si, hold_n, so, so_oe, standby, busy;
	int miscompares = 0;
	int checks_done = 0;
	int seed = 10;
	int n;
	logic [7:0] mem [0:16383];
	logic [7:0] wbuf [0:63];
	logic [7:0] rbuf [0:63];
	logic [1:0] bp = 2'h0;
	logic [13:0] a;
	logic [13:0] pa [6] = '{14'h0000, 14'h1FFF, 14'h2000, 14'h2FFF, 14'h3000, 14'h3FFF};
	sees_top #(.WRITE_CYCLES(WC)) sees_top_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.spi_sck_in(sck), .spi_cs_n_in(cs_n), .spi_si_in(si), .spi_hold_n_in(hold_n),
		.wp_n_in(wp_n_in), .spi_so_out(so), .spi_so_oe_out(so_oe), .standby_out(standby),
		.write_busy_out(busy));
	sees_host_model host_i (.so_in(so), .so_oe_in(so_oe), .sck_out(sck), .cs_n_out(cs_n),
		.si_out(si), .hold_n_out(hold_n));
	// system clock
	initial
	begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	task finish_test;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask : chk
	// protected range for the current block protect code
	function logic prot(input logic [13:0] ad);
		return bp == 2'h3 || (bp == 2'h2 && ad[13]) || (bp == 2'h1 && ad[13:12] == 2'h3);
	endfunction : prot
	// one frame: opcode, optional address, writes, then reads
	task frm(input logic [7:0] op, input logic na, input logic [15:0] ad, input int nw, input int nr);
		logic [7:0] d;
		host_i.start();
		host_i.xfer(op, d);
		if (na)
		begin
			host_i.xfer(ad[15:8], d);
			host_i.xfer(ad[7:0], d);
		end
		for (int i = 0; i < nw; i++)
			host_i.xfer(wbuf[i], d);
		for (int i = 0; i < nr; i++)
			host_i.xfer(8'($random(seed)), rbuf[i]);
		host_i.stop();
	endtask : frm
	// poll status until ready, bounded
	task rdy;
		for (int k = 0; k < 100; k++)
		begin
			frm(8'h05, 0, 16'h0, 0, 1);
			if (rbuf[0][0] === 1'b0)
				break;
		end
		chk(rbuf[0] & 8'h01, 8'h00);
	endtask : rdy
	task wra(input logic [13:0] ad, input int cnt, input logic en);
		for (int i = 0; i < cnt; i++)
			wbuf[i] = 8'($random(seed));
		if (en)
			frm(8'h06, 0, 16'h0, 0, 0);
		frm(8'h02, 1, {2'h0, ad}, cnt, 0);
		if (en)
		begin
			frm(8'h05, 0, 16'h0, 0, 1);
			chk(rbuf[0], 8'hFF);
			frm(8'h06, 0, 16'h0, 0, 0);
		end
		for (int i = 0; i < cnt; i++)
			if (en && !prot(ad))
				mem[{ad[13:6], 6'(ad[5:0] + i)}] = wbuf[i];
		rdy();
		chk(rbuf[0], {4'h0, bp, 2'h0});
	endtask : wra
	task rda(input logic [13:0] ad, input int cnt);
		frm(8'h03, 1, {2'h0, ad}, 0, cnt);
		for (int i = 0; i < cnt; i++)
			chk(rbuf[i], mem[14'(ad + i)]);
	endtask : rda
	task wrs(input logic [7:0] v);
		frm(8'h06, 0, 16'h0, 0, 0);
		wbuf[0] = v;
		frm(8'h01, 0, 16'h0, 1, 0);
		rdy();
	endtask : wrs
	task rst_pulse;
		@(negedge clk_sys_in) rst_in = 1'b1;
		repeat (10) @(negedge clk_sys_in);
		rst_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		foreach (mem[i]) mem[i] = 8'h00;
		chk({6'h0, standby, busy}, 8'h02);
	endtask : rst_pulse
	// hang guard, well beyond the expected run
	initial
	begin
		#500000;
		miscompares++;
		finish_test();
	end
	// main sequence
	initial
	begin
		rst_in = 1'b1;
		wp_n_in = 1'b1;
		rst_pulse();
		frm(8'h05, 0, 16'h0, 0, 1);
		chk(rbuf[0], 8'h00);
		for (int m = 0; m < 2; m++)
		begin
			host_i.cpol = m[0];
			frm(8'h06, 0, 16'h0, 0, 0);
			frm(8'h05, 0, 16'h0, 0, 1);
			chk(rbuf[0], 8'h02);
			frm(8'h04, 0, 16'h0, 0, 0);
			frm(8'h46, 0, 16'h0, 0, 0);
			frm(8'h05, 0, 16'h0, 0, 1);
			chk(rbuf[0], 8'h00);
			a = 14'($random(seed));
			n = 1 + ($random(seed) & 63);
			wra(a, 1, 1'b0);
			rda(a, 1);
			wra(a, m ? 64 : n, 1'b1);
			rda({a[13:6], 6'h00}, 64);
			host_i.hold_bit = 3;
			rda(a, 3);
			host_i.hold_bit = -1;
		end
		for (int b = 0; b < 4; b++)
		begin
			bp = b[1:0];
			wrs({4'h0, bp, 2'h0});
			chk(rbuf[0], {4'h0, bp, 2'h0});
			foreach (pa[i])
			begin
				wra(pa[i], 1, 1'b1);
				rda(pa[i], 1);
			end
		end
		bp = 2'h0;
		wrs(8'h80);
		@(negedge clk_sys_in) wp_n_in = 1'b0;
		wrs(8'h8C);
		chk(rbuf[0] & 8'hFC, 8'h80);
		@(negedge clk_sys_in) wp_n_in = 1'b1;
		wrs(8'h00);
		chk(rbuf[0] & 8'hFC, 8'h00);
		// identification page: write, lock, refused rewrite
		wbuf[0] = 8'($random(seed));
		frm(8'h06, 0, 16'h0, 0, 0);
		frm(8'h82, 1, 16'h0005, 1, 0);
		rdy();
		frm(8'h06, 0, 16'h0, 0, 0);
		frm(8'h82, 1, 16'h0400, 1, 0);
		rdy();
		frm(8'h83, 1, 16'h0400, 0, 1);
		chk(rbuf[0], 8'h01);
		wbuf[0] = ~wbuf[0];
		frm(8'h06, 0, 16'h0, 0, 0);
		frm(8'h82, 1, 16'h0005, 1, 0);
		rdy();
		frm(8'h83, 1, 16'h0005, 0, 1);
		chk(rbuf[0], ~wbuf[0]);
		// reset in the middle of a write cycle
		frm(8'h06, 0, 16'h0, 0, 0);
		frm(8'h02, 1, 16'h0100, 1, 0);
		repeat (20) @(negedge clk_sys_in);
		chk({7'h0, busy}, 8'h01);
		rst_pulse();
		frm(8'h05, 0, 16'h0, 0, 1);
		chk(rbuf[0], 8'h00);
		finish_test();
	end
endmodule : sees_top_bench
